// [design/exs_pkg.sv]
// constants for the external switch inputs block: register map, fields, reset values, timing
// assumes one 100 MHz system clock and the plain strobe register port of the top module
package exs_pkg;

  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 32;

  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_TMO       = 8'h04;
  localparam logic [7:0]  ADDR_STATUS    = 8'h08;

  // control register fields
  localparam int          CTRL_SET_LSB   = 0;
  localparam int          CTRL_TP_BIT    = 3;
  localparam int          CTRL_LNK_BIT   = 4;
  localparam int          CTRL_EARLY_BIT = 5;

  // status register fields
  localparam int          ST_SET_LSB     = 0;
  localparam int          ST_TA_BIT      = 3;
  localparam int          ST_LNK_BIT     = 4;
  localparam int          ST_PLVL_BIT    = 5;
  localparam int          ST_TLVL_BIT    = 6;
  localparam int          ST_RUN_BIT     = 7;

  localparam logic [2:0]  SET_EXTERNAL   = 3'h0;
  localparam logic [2:0]  SET_ONE        = 3'h1;
  localparam logic [2:0]  SET_TWO        = 3'h2;
  localparam logic [2:0]  SET_MAX        = 3'h6;
  localparam logic [2:0]  SET_RESET      = 3'h1;
  localparam logic [7:0]  TMO_LEVEL      = 8'h00;
  localparam logic [7:0]  TMO_RESET      = 8'h00;

  localparam int          CLK_PERIOD_NS  = 10;
  localparam int          TMO_UNIT_MS    = 1000;
  localparam int          DEBOUNCE_MS    = 5;
  localparam int          TMO_UNIT_CYC   = TMO_UNIT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int          DEBOUNCE_CYC   = DEBOUNCE_MS * 1000000 / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_LEVEL  = 3'b001,
    ST_IDLE   = 3'b010,
    ST_ACTIVE = 3'b100
  } exs_state_t;

endpackage

// [design/exs_switch_inputs.sv]
// external program set switch and traffic switch logic with a small register port
// assumes switch pins are synchronous-sampled levels, high when open; registers read one cycle late
//
// The plain strobed port and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none

module exs_switch_inputs
  import exs_pkg::*;
#(
  parameter int unsigned UNIT_CYCLES     = TMO_UNIT_CYC,
  parameter int unsigned DEBOUNCE_CYCLES = DEBOUNCE_CYC
)
(
  input  wire logic              sys_clk,
  input  wire logic              reset,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [DATA_W-1:0]      reg_rdata,
  input  wire logic              prog_switch_n,
  input  wire logic              traffic_switch_n,
  output logic [2:0]             active_program_set,
  output logic                   traffic_announcement_flag,
  output logic                   linked_network_traffic_flag
);

  // software state
  logic [2:0]        set_sel_reg;
  logic              local_tp_reg;
  logic              first_linked_network_enable_reg;
  logic              early_clear_reg;
  logic [7:0]        traffic_timeout_setting_reg;
  logic [DATA_W-1:0] rdata_reg;

  // input conditioning, bit 0 program, bit 1 traffic
  logic [1:0]        sync1_reg;
  logic [1:0]        sync2_reg;
  logic [1:0]        stable_reg;
  logic [1:0]        prev_reg;
  logic [31:0]       deb_cnt_reg [2];

  // traffic timing
  exs_state_t        state_reg;
  exs_state_t        state_next;
  logic [7:0]        remain_reg;
  logic [7:0]        remain_next;
  logic [31:0]       unit_cnt_reg;
  logic [2:0]        active_set_reg;
  logic              ta_flag_reg;
  logic              lnk_flag_reg;

  wire sel_ctrl    = (reg_addr == ADDR_CTRL);
  wire sel_tmo     = (reg_addr == ADDR_TMO);
  wire sel_status  = (reg_addr == ADDR_STATUS);
  wire wr_ctrl     = reg_wr & sel_ctrl;
  wire wr_tmo      = reg_wr & sel_tmo;
  wire [2:0] wr_set = reg_wdata[CTRL_SET_LSB +: 3];
  // set numbers above six are not stored sets, so such a write leaves the field alone
  wire set_ok      = (wr_set <= SET_MAX);

  wire prog_lvl    = stable_reg[0];
  wire ta_lvl      = stable_reg[1];
  wire ta_fall     = prev_reg[1] & ~stable_reg[1];
  wire ta_rise     = ~prev_reg[1] & stable_reg[1];
  wire edge_mode   = (traffic_timeout_setting_reg != TMO_LEVEL);
  wire ta_route    = local_tp_reg;
  wire lnk_route   = ~local_tp_reg & first_linked_network_enable_reg;
  wire unit_tick   = (unit_cnt_reg == UNIT_CYCLES - 1);

  // switch open (high) picks set one, closed picks set two
  wire [2:0] ext_set        = prog_lvl ? SET_ONE : SET_TWO;
  wire [2:0] active_set_nxt = (set_sel_reg == SET_EXTERNAL) ? ext_set : set_sel_reg;

  wire [DATA_W-1:0] ctrl_word =
    {{(DATA_W-6){1'b0}}, early_clear_reg, first_linked_network_enable_reg, local_tp_reg, set_sel_reg};
  wire [DATA_W-1:0] tmo_word  = {{(DATA_W-8){1'b0}}, traffic_timeout_setting_reg};
  wire [DATA_W-1:0] stat_word =
    {{(DATA_W-8){1'b0}}, (state_reg == ST_ACTIVE), ta_lvl, prog_lvl, lnk_flag_reg, ta_flag_reg,
     active_set_reg};
  wire [DATA_W-1:0] rd_mux    = sel_ctrl   ? ctrl_word :
                                sel_tmo    ? tmo_word  :
                                sel_status ? stat_word : '0;

  // the linked flag is a plain level copy, edge mode never reaches it
  wire lnk_flag_nxt = lnk_route & ~ta_lvl;
  // level mode copies the inverted pin; edge mode shows the timer state
  wire ta_flag_nxt  = ta_route & (edge_mode ? (state_next == ST_ACTIVE) : ~ta_lvl);

  always_comb
  begin
    state_next  = state_reg;
    remain_next = remain_reg;
    if (!edge_mode)
    begin
      state_next = ST_LEVEL;
    end
    else if (!ta_route)
    begin
      // an unrouted switch must not arm a timer that shows once the route opens
      state_next = ST_IDLE;
    end
    else
    begin
      case (state_reg)
        ST_LEVEL:
        begin
          state_next = ST_IDLE;
        end
        ST_IDLE:
        begin
          if (ta_fall)
          begin
            state_next  = ST_ACTIVE;
            remain_next = traffic_timeout_setting_reg;
          end
        end
        ST_ACTIVE:
        begin
          if (ta_fall)
          begin
            remain_next = traffic_timeout_setting_reg;
          end
          else if (ta_rise && early_clear_reg)
          begin
            state_next = ST_IDLE;
          end
          else if (unit_tick)
          begin
            if (remain_reg <= 8'h01)
            begin
              state_next = ST_IDLE;
            end
            remain_next = remain_reg - 8'h01;
          end
        end
        default:
        begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      set_sel_reg                     <= SET_RESET;
      local_tp_reg                    <= 1'b0;
      first_linked_network_enable_reg <= 1'b0;
      early_clear_reg                 <= 1'b0;
      traffic_timeout_setting_reg     <= TMO_RESET;
    end
    else if (wr_ctrl)
    begin
      if (set_ok)
      begin
        set_sel_reg <= wr_set;
      end
      local_tp_reg                    <= reg_wdata[CTRL_TP_BIT];
      first_linked_network_enable_reg <= reg_wdata[CTRL_LNK_BIT];
      early_clear_reg                 <= reg_wdata[CTRL_EARLY_BIT];
    end
    else if (wr_tmo)
    begin
      traffic_timeout_setting_reg <= reg_wdata[7:0];
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      rdata_reg <= '0;
    end
    else if (reg_rd)
    begin
      rdata_reg <= rd_mux;
    end
  end

  // two-stage synchroniser, then a level must hold for the whole filter window
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      sync1_reg      <= 2'b11;
      sync2_reg      <= 2'b11;
      stable_reg     <= 2'b11;
      prev_reg       <= 2'b11;
      deb_cnt_reg[0] <= '0;
      deb_cnt_reg[1] <= '0;
    end
    else
    begin
      sync1_reg <= {traffic_switch_n, prog_switch_n};
      sync2_reg <= sync1_reg;
      prev_reg  <= stable_reg;
      for (int i = 0; i < 2; i++)
      begin
        if (sync2_reg[i] == stable_reg[i])
        begin
          deb_cnt_reg[i] <= '0;
        end
        else if (deb_cnt_reg[i] >= DEBOUNCE_CYCLES - 1)
        begin
          stable_reg[i]  <= sync2_reg[i];
          deb_cnt_reg[i] <= '0;
        end
        else
        begin
          deb_cnt_reg[i] <= deb_cnt_reg[i] + 32'h0000_0001;
        end
      end
    end
  end

  // the unit prescaler restarts on every fall so a timeout is exactly whole units long
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      unit_cnt_reg <= '0;
    end
    else if (ta_fall || unit_tick || state_reg != ST_ACTIVE)
    begin
      unit_cnt_reg <= '0;
    end
    else
    begin
      unit_cnt_reg <= unit_cnt_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      state_reg      <= ST_LEVEL;
      remain_reg     <= 8'h00;
      active_set_reg <= SET_RESET;
      ta_flag_reg    <= 1'b0;
      lnk_flag_reg   <= 1'b0;
    end
    else
    begin
      state_reg      <= state_next;
      remain_reg     <= remain_next;
      active_set_reg <= active_set_nxt;
      ta_flag_reg    <= ta_flag_nxt;
      lnk_flag_reg   <= lnk_flag_nxt;
    end
  end

  assign reg_rdata                   = rdata_reg;
  assign active_program_set          = active_set_reg;
  assign traffic_announcement_flag   = ta_flag_reg;
  assign linked_network_traffic_flag = lnk_flag_reg;

  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_ext_set_select: assert property (
    set_sel_reg == SET_EXTERNAL && prog_lvl |=> active_program_set == SET_ONE)
    else $error("external open switch did not select set one");

  a_closed_set_two: assert property (
    set_sel_reg == SET_EXTERNAL && !prog_lvl |=> active_program_set == SET_TWO)
    else $error("external closed switch did not select set two");

  a_direct_set_sel: assert property (
    set_sel_reg != SET_EXTERNAL |=> active_program_set == $past(set_sel_reg))
    else $error("direct set selection not followed");

  a_level_mode_flag: assert property (
    ta_route && !edge_mode |=> traffic_announcement_flag == !$past(ta_lvl))
    else $error("level mode traffic flag does not follow input");

  a_fall_sets_flag: assert property (
    ta_route && edge_mode && state_reg != ST_LEVEL && ta_fall |=> traffic_announcement_flag)
    else $error("falling edge did not raise traffic flag");

  a_timeout_clears: assert property (
    ta_route && edge_mode && state_reg == ST_ACTIVE && unit_tick && remain_reg == 8'h01 && !ta_fall
    |=> !traffic_announcement_flag)
    else $error("traffic flag not cleared at timeout");

  a_early_rise_clear: assert property (
    edge_mode && state_reg == ST_ACTIVE && early_clear_reg && ta_rise |=> !traffic_announcement_flag)
    else $error("rising edge did not clear flag early");

  a_linked_follows: assert property (
    lnk_route |=> linked_network_traffic_flag == !$past(ta_lvl))
    else $error("linked flag does not follow input level");

  a_route_disabled: assert property (
    !local_tp_reg |=> !traffic_announcement_flag
      && ($past(first_linked_network_enable_reg) || !linked_network_traffic_flag))
    else $error("switch drives a flag it is not routed to");

  a_filter_holds: assert property (
    sync2_reg[1] != stable_reg[1] && deb_cnt_reg[1] < DEBOUNCE_CYCLES - 1 |=> $stable(stable_reg[1]))
    else $error("traffic input changed before filter window");

  a_unmapped_read: assert property (
    reg_rd && !sel_ctrl && !sel_tmo && !sel_status |=> reg_rdata == '0)
    else $error("unmapped read not zero");

endmodule

`default_nettype wire

// [test/exs_switch_model.sv]
// model of the two external contacts wired to the switch pins
// assumes pull-ups on both pins, so an open contact reads high
`timescale 1ns/100ps
`default_nettype none

module exs_switch_model
(
  input  wire logic prog_closed,
  input  wire logic traffic_closed,
  input  wire logic traffic_glitch,
  output logic      prog_switch_n,
  output logic      traffic_switch_n
);
  // glitch stands for contact bounce, shorter than the filter span
  assign prog_switch_n    = ~prog_closed;
  assign traffic_switch_n = ~(traffic_closed | traffic_glitch);
endmodule

`default_nettype wire

// [test/exs_switch_inputs_tb.sv]
// self-checking bench for the external switch inputs block
// assumes the switch model file and the design package are compiled first
`timescale 1ns/100ps
`default_nettype none

module exs_switch_inputs_tb;
  import exs_pkg::*;
  localparam int UNIT = 10;
  localparam int DEB  = 4;
  logic              sys_clk, reset, reg_wr, reg_rd;
  logic              prog_closed, traffic_closed, traffic_glitch;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, rdata_q;
  logic              prog_switch_n, traffic_switch_n;
  logic [2:0]        active_program_set;
  logic              traffic_announcement_flag, linked_network_traffic_flag;
  int                mismatches, checked;

  exs_switch_model sw (.prog_closed(prog_closed), .traffic_closed(traffic_closed),
    .traffic_glitch(traffic_glitch), .prog_switch_n(prog_switch_n), .traffic_switch_n(traffic_switch_n));

  exs_switch_inputs #(.UNIT_CYCLES(UNIT), .DEBOUNCE_CYCLES(DEB)) uut (.sys_clk(sys_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .prog_switch_n(prog_switch_n), .traffic_switch_n(traffic_switch_n),
    .active_program_set(active_program_set), .traffic_announcement_flag(traffic_announcement_flag),
    .linked_network_traffic_flag(linked_network_traffic_flag));

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic stop_test();
    $display("compares %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ends just past an edge so outputs have settled
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    rdata_q = reg_rdata;
  endtask

  task automatic chk_rd(input logic [31:0] exp);
    checked++;
    if (rdata_q !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t read got %h exp %h", $time, rdata_q, exp);
    end
  endtask

  task automatic chk_out(input logic [2:0] set, input logic ta, input logic lnk);
    logic [4:0] got;
    got = {active_program_set, traffic_announcement_flag, linked_network_traffic_flag};
    checked++;
    if (got !== {set, ta, lnk})
    begin
      mismatches++;
      $display("MISMATCH t=%0t outputs got %h exp %h", $time, got, {set, ta, lnk});
    end
  endtask

  // switch changes need sync plus debounce plus one output stage
  localparam int SETTLE = DEB + 8;

  initial
  begin
    reset = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    prog_closed = 1'b0;
    traffic_closed = 1'b0;
    traffic_glitch = 1'b0;
    mismatches = 0;
    checked = 0;
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    wt(1);
    chk_out(SET_RESET, 1'b0, 1'b0);
    rd(ADDR_CTRL);
    chk_rd(32'h0000_0001);
    rd(ADDR_TMO);
    chk_rd(32'h0000_0000);
    rd(8'hFC);
    chk_rd(32'h0000_0000);
    wr(ADDR_STATUS, 32'hFFFF_FFFF);
    rd(ADDR_STATUS);
    chk_rd(32'h0000_0061);
    for (int i = 1; i <= 6; i++)
    begin
      wr(ADDR_CTRL, i);
      wt(3);
      chk_out(i[2:0], 1'b0, 1'b0);
    end
    wr(ADDR_CTRL, 32'h0000_0007);
    wt(3);
    chk_out(3'h6, 1'b0, 1'b0);
    prog_closed <= 1'b1;
    wr(ADDR_CTRL, 32'h0000_0003);
    wt(SETTLE);
    chk_out(3'h3, 1'b0, 1'b0);
    wr(ADDR_CTRL, 32'h0000_0000);
    wt(3);
    chk_out(SET_TWO, 1'b0, 1'b0);
    prog_closed <= 1'b0;
    wt(SETTLE);
    chk_out(SET_ONE, 1'b0, 1'b0);
    wr(ADDR_CTRL, 32'h0000_0008);
    traffic_closed <= 1'b1;
    wt(SETTLE);
    chk_out(SET_ONE, 1'b1, 1'b0);
    traffic_closed <= 1'b0;
    wt(SETTLE);
    chk_out(SET_ONE, 1'b0, 1'b0);
    @(posedge sys_clk);
    traffic_glitch <= 1'b1;
    repeat (2) @(posedge sys_clk);
    traffic_glitch <= 1'b0;
    // looked at while an unfiltered glitch would still show on the flag
    wt(2);
    chk_out(SET_ONE, 1'b0, 1'b0);
    wt(SETTLE);
    chk_out(SET_ONE, 1'b0, 1'b0);
    wr(ADDR_TMO, 32'h0000_0002);
    wr(ADDR_CTRL, 32'h0000_0010);
    traffic_closed <= 1'b1;
    wt(SETTLE);
    chk_out(SET_ONE, 1'b0, 1'b1);
    wt(3 * UNIT);
    chk_out(SET_ONE, 1'b0, 1'b1);
    traffic_closed <= 1'b0;
    wt(SETTLE);
    chk_out(SET_ONE, 1'b0, 1'b0);
    wr(ADDR_CTRL, 32'h0000_0000);
    traffic_closed <= 1'b1;
    wt(SETTLE);
    chk_out(SET_ONE, 1'b0, 1'b0);
    traffic_closed <= 1'b0;
    wt(SETTLE);
    wr(ADDR_CTRL, 32'h0000_0008);
    traffic_closed <= 1'b1;
    wt(SETTLE);
    chk_out(SET_ONE, 1'b1, 1'b0);
    // flag rises one edge after the filtered fall and stands two whole units
    wt(2 * UNIT - 6);
    chk_out(SET_ONE, 1'b1, 1'b0);
    wt(1);
    chk_out(SET_ONE, 1'b0, 1'b0);
    traffic_closed <= 1'b0;
    wt(SETTLE);
    wr(ADDR_TMO, 32'h0000_0005);
    wr(ADDR_CTRL, 32'h0000_0028);
    traffic_closed <= 1'b1;
    wt(SETTLE);
    chk_out(SET_ONE, 1'b1, 1'b0);
    traffic_closed <= 1'b0;
    wt(SETTLE);
    chk_out(SET_ONE, 1'b0, 1'b0);
    stop_test();
  end

  // whole sequence needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    mismatches++;
    stop_test();
  end
endmodule

`default_nettype wire
